// [logic/csw_pkg.sv]
// Shared constants for the CAN selective wake frame filter.
package csw_pkg;

  // ==========================================
  // Frame field widths
  localparam int STD_ID_W = 11;
  localparam int EXT_ID_W = 29;
  localparam int DLC_W    = 4;
  localparam int DATA_W   = 64;
  localparam int CNT_W    = 6;

  // ==========================================
  // Error counter limits and decoder resync
  localparam logic [CNT_W-1:0] CNT_LIMIT = 6'h1f;
  localparam logic [CNT_W-1:0] CNT_OVF   = 6'h20;
  localparam logic [CNT_W-1:0] CNT_RST   = 6'h00;
  localparam logic [3:0] REC_WAIT_MIN    = 4'h6;
  localparam logic [3:0] REC_WAIT_MAX    = 4'ha;
  localparam logic [3:0] REC_WAIT_BITS   = 4'h8;
  localparam logic [2:0] BIAS_SKIP_MAX   = 3'h4;

  // ==========================================
  // Transceiver mode codes
  localparam logic [2:0] CAN_OFF_LO   = 3'h0;
  localparam logic [2:0] CAN_WAKE     = 3'h1;
  localparam logic [2:0] CAN_OFF_HI   = 3'h4;

  // ==========================================
  // Chip operating modes
  localparam logic [1:0] SBC_NORMAL  = 2'h0;
  localparam logic [1:0] SBC_STOP    = 2'h1;
  localparam logic [1:0] SBC_SLEEP   = 2'h2;
  localparam logic [1:0] SBC_RESTART = 2'h3;

  // ==========================================
  // Selective wake states
  typedef enum logic [2:0] {
    CSW_OFF,
    CSW_WUF_DET,
    CSW_WUP_DET1,
    CSW_WUP_DET2,
    CSW_WOKEN
  } csw_state_t;

endpackage

// [logic/csw_frame_match.sv]
// Wake frame filter: identifier, length and data mask comparison.
`timescale 1ns/1ps
`default_nettype none
module csw_frame_match
  import csw_pkg::*;
(
  // Received frame
  input  wire logic [EXT_ID_W-1:0] rx_id,
  input  wire logic                rx_ext,
  input  wire logic [DLC_W-1:0]    rx_dlc,
  input  wire logic [DATA_W-1:0]   rx_data,
  // Filter configuration
  input  wire logic [EXT_ID_W-1:0] cfg_id,
  input  wire logic [EXT_ID_W-1:0] cfg_id_mask,
  input  wire logic                cfg_ext,
  input  wire logic [DLC_W-1:0]    cfg_dlc,
  input  wire logic [DATA_W-1:0]   cfg_data_mask,
  // Result
  output logic                     match
);

  // Lengths above eight still carry only eight data bytes here.
  function automatic logic [DATA_W-1:0] bytes_mask(input logic [DLC_W-1:0] dlc);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(dlc)) begin
        m[i*8 +: 8] = 8'hff;
      end
    end
    return m;
  endfunction

  logic [EXT_ID_W-1:0] id_sel;
  logic                id_ok;
  logic                data_ok;

  always_comb begin
    id_sel = cfg_ext ? cfg_id_mask : {{(EXT_ID_W-STD_ID_W){1'b0}}, cfg_id_mask[STD_ID_W-1:0]};
    id_ok  = (rx_ext == cfg_ext) && (((rx_id ^ cfg_id) & id_sel) == '0);
    data_ok = (rx_dlc == '0) || ((rx_data & cfg_data_mask & bytes_mask(rx_dlc)) != '0);
    match = id_ok && (rx_dlc == cfg_dlc) && data_ok;
  end

endmodule
`default_nettype wire

// [logic/csw_err_counter.sv]
// Protocol error counter with overflow detection and freeze.
`timescale 1ns/1ps
`default_nettype none
module csw_err_counter
  import csw_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Control
  input  wire logic             active,
  input  wire logic             inc,
  input  wire logic             dec,
  input  wire logic             clear,
  input  wire logic             freeze,
  // Status
  output logic [CNT_W-1:0]      count,
  output logic                  overflow,
  output logic                  step
);

  logic run;

  assign run      = active && !freeze && !clear;
  assign overflow = run && inc && (count == CNT_LIMIT);
  assign step     = run && (inc || (dec && count != '0));

  // ==========================================
  // Counter
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= CNT_RST;
    end else if (clear) begin
      count <= CNT_RST;
    end else if (run && inc) begin
      if (count != CNT_OVF) begin
        count <= count + 6'h01;
      end
    end else if (run && dec && count != '0) begin
      count <= count - 6'h01;
    end
  end

  // ==========================================
  // Checks
  chk_cnt_limit: assert property (@(posedge clk) disable iff (!reset_n) count <= CNT_OVF)
    else $error("error count above overflow value");
  chk_cnt_clear: assert property (@(posedge clk) disable iff (!reset_n) clear |=> count == '0)
    else $error("error count not cleared");
  chk_cnt_freeze: assert property (@(posedge clk) disable iff (!reset_n)
    (freeze && !clear) |=> $stable(count))
    else $error("error count moved while frozen");
  chk_cnt_inc: assert property (@(posedge clk) disable iff (!reset_n)
    (run && inc && count < CNT_OVF) |=> count == $past(count) + 6'h01)
    else $error("error count missed an increment");

endmodule
`default_nettype wire

// [logic/csw_selwake.sv]
// Selective wake top: frame wake, error counter control and flags.
//
// Functional notes
// - Wake on valid frame; may skip four frames.
// - Masked identifier must match, 11 or 29 bits.
// - Length code must equal configured length.
// - Nonzero length needs masked data bit set.
// - Errors outside acknowledge and end disqualify.
// - Count up on errors, down on good frames.
// - Overflow past 31 disables, wakes, reads 32.
// - After count step wait recessive bits.
// - Counter runs in normal, receive, frame detect.
// - Clear counter on entry, silence, rearm.
// - Clear counter in off or plain wake.
// - Tolerance plus count disable hold zero.
// - Counter frozen while woken, still readable.
// - Power-on sets flag, resets, unconfigured.
// - Report bus and transmit dominant timeouts.
// - Pattern flag set on pattern wakes.
// - Frame wake sets flags, restart or interrupt.
// - Frame flag clears on next rearm.
// - System error on config or overflow.
// - Config check on enable; range writes in normal mode invalidate.
// - Restart clears valid; may flag error.
// - Error flag sticks while invalid config.
`timescale 1ns/1ps
`default_nettype none
module csw_selwake
  import csw_pkg::*;
#(
  parameter logic [2:0] SKIP_FRAMES = 3'h0
)(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                reset_n,
  // Operating modes
  input  wire logic [1:0]          sbc_mode,
  input  wire logic [2:0]          can_mode,
  input  wire logic                fd_tolerance_enable,
  input  wire logic                error_count_disable,
  // Host controls
  input  wire logic                config_valid_set,
  input  wire logic                config_range_write,
  input  wire logic                selwake_control_write,
  input  wire logic                selwake_system_error_clear,
  input  wire logic                bus_wake_clear,
  input  wire logic                bus_fail_clear,
  input  wire logic                por_clear,
  input  wire logic                rearm,
  // Filter configuration
  input  wire logic [EXT_ID_W-1:0] cfg_id,
  input  wire logic [EXT_ID_W-1:0] cfg_id_mask,
  input  wire logic                cfg_ext,
  input  wire logic [DLC_W-1:0]    cfg_dlc,
  input  wire logic [DATA_W-1:0]   cfg_data_mask,
  // Frame decoder
  input  wire logic                frame_done,
  input  wire logic                frame_crc_ok,
  input  wire logic                frame_error,
  input  wire logic [EXT_ID_W-1:0] rx_id,
  input  wire logic                rx_ext,
  input  wire logic [DLC_W-1:0]    rx_dlc,
  input  wire logic [DATA_W-1:0]   rx_data,
  input  wire logic                stuff_err,
  input  wire logic                crc_err,
  input  wire logic                form_err,
  input  wire logic                bit_strobe,
  input  wire logic                rx_recessive,
  // Bus events
  input  wire logic                bias_on,
  input  wire logic                silence_timeout,
  input  wire logic                pattern_detected,
  input  wire logic                bus_dom_timeout,
  input  wire logic                txd_dom_timeout,
  // Wake outputs
  output logic                     wake_out,
  output logic                     restart_request,
  output logic                     wake_interrupt,
  // Status
  output logic                     wake_pattern,
  output logic                     wake_frame,
  output logic                     bus_wake_flag,
  output logic                     selwake_system_error,
  output logic                     config_valid_bit,
  output logic                     selwake_active,
  output logic                     sof_enable,
  output logic [CNT_W-1:0]         frame_error_count,
  output logic [1:0]               bus_fail,
  output logic                     por_flag
);

  // ==========================================
  // Decode
  csw_state_t state_reg;
  csw_state_t state_next;
  logic       match;
  logic       swk_mode;
  logic       swk_on;
  logic       cfg_err;
  logic       check_ok;
  logic       check_bad;
  logic       frame_wake;
  logic       plain_pat;
  logic       pat_wake;
  logic       cnt_ovf;
  logic       cnt_step;
  logic       cnt_clear;
  logic       cnt_active;
  logic       restart_entry;
  logic       restart_err;
  logic       selwake_system_error_set;
  logic       skip_done;
  logic [1:0] mode_prev_reg;
  logic [2:0] skip_reg;
  logic [3:0] rec_reg;
  logic       frame_restart_reg;

  // Config range writes change the filter; a control-only write does not.
  assign swk_mode   = can_mode[2] && (can_mode[1:0] != 2'h0);
  assign swk_on     = (state_reg == CSW_WUF_DET) || (state_reg == CSW_WUP_DET1);
  assign cfg_err    = swk_on && config_range_write && (sbc_mode == SBC_NORMAL);
  assign check_ok   = (state_reg == CSW_OFF) && swk_mode && config_valid_bit;
  assign check_bad  = (state_reg == CSW_OFF) && swk_mode && !config_valid_bit;
  assign skip_done  = (skip_reg >= SKIP_FRAMES);
  assign frame_wake = (state_reg == CSW_WUF_DET) && swk_mode && frame_done && match
                      && !frame_error && skip_done && !cfg_err;
  assign plain_pat  = (state_reg == CSW_OFF) && (can_mode == CAN_WAKE) && pattern_detected;
  assign pat_wake   = ((state_reg == CSW_WUP_DET2) && pattern_detected) || plain_pat;
  assign restart_entry = (sbc_mode == SBC_RESTART) && (mode_prev_reg != SBC_RESTART);
  assign restart_err   = restart_entry && swk_on && !frame_restart_reg;
  assign selwake_system_error_set    = swk_mode && (check_bad || cfg_err || restart_err
                         || (swk_on && cnt_ovf));
  assign cnt_active = can_mode[1] || (state_reg == CSW_WUF_DET);
  assign cnt_clear  = (can_mode == CAN_OFF_LO) || (can_mode == CAN_OFF_HI)
                      || (can_mode == CAN_WAKE)
                      || (fd_tolerance_enable && error_count_disable)
                      || check_ok
                      || (state_reg == CSW_WUF_DET && silence_timeout)
                      || (state_reg == CSW_WUP_DET1 && pattern_detected)
                      || (state_reg == CSW_WOKEN && rearm);

  csw_frame_match u_match (
    .rx_id         (rx_id),
    .rx_ext        (rx_ext),
    .rx_dlc        (rx_dlc),
    .rx_data       (rx_data),
    .cfg_id        (cfg_id),
    .cfg_id_mask   (cfg_id_mask),
    .cfg_ext       (cfg_ext),
    .cfg_dlc       (cfg_dlc),
    .cfg_data_mask (cfg_data_mask),
    .match         (match)
  );

  csw_err_counter u_cnt (
    .clk      (clk),
    .reset_n  (reset_n),
    .active   (cnt_active),
    .inc      (stuff_err || crc_err || form_err),
    .dec      (frame_done && frame_crc_ok),
    .clear    (cnt_clear),
    .freeze   (state_reg == CSW_WOKEN),
    .count    (frame_error_count),
    .overflow (cnt_ovf),
    .step     (cnt_step)
  );

  // ==========================================
  // State machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CSW_OFF: begin
        if (check_ok) begin
          state_next = CSW_WUF_DET;
        end else if (check_bad) begin
          state_next = CSW_WUP_DET2;
        end
      end
      CSW_WUF_DET: begin
        if (!swk_mode) begin
          state_next = CSW_OFF;
        end else if (cnt_ovf || frame_wake) begin
          state_next = CSW_WOKEN;
        end else if (cfg_err || restart_err) begin
          state_next = CSW_WUP_DET2;
        end else if (silence_timeout) begin
          state_next = CSW_WUP_DET1;
        end
      end
      CSW_WUP_DET1: begin
        if (!swk_mode) begin
          state_next = CSW_OFF;
        end else if (cnt_ovf) begin
          state_next = CSW_WOKEN;
        end else if (cfg_err || restart_err) begin
          state_next = CSW_WUP_DET2;
        end else if (pattern_detected) begin
          state_next = CSW_WUF_DET;
        end
      end
      CSW_WUP_DET2: begin
        if (!swk_mode) begin
          state_next = CSW_OFF;
        end else if (pattern_detected) begin
          state_next = CSW_WOKEN;
        end
      end
      CSW_WOKEN: begin
        if (rearm) begin
          state_next = CSW_OFF;
        end
      end
      default: state_next = CSW_OFF;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg      <= CSW_OFF;
      selwake_active <= 1'b0;
    end else begin
      state_reg      <= state_next;
      selwake_active <= (state_next == CSW_WUF_DET) || (state_next == CSW_WUP_DET1);
    end
  end

  // ==========================================
  // Wake outputs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_out        <= 1'b0;
      restart_request <= 1'b0;
      wake_interrupt  <= 1'b0;
    end else begin
      wake_out        <= frame_wake || pat_wake || (swk_on && cnt_ovf);
      restart_request <= frame_wake && (sbc_mode == SBC_SLEEP);
      wake_interrupt  <= frame_wake && (sbc_mode != SBC_SLEEP)
                         && (sbc_mode != SBC_RESTART);
    end
  end

  // Mode history tells a frame-driven restart from any other restart.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_prev_reg     <= SBC_NORMAL;
      frame_restart_reg <= 1'b0;
    end else begin
      mode_prev_reg <= sbc_mode;
      if (frame_wake && sbc_mode == SBC_SLEEP) begin
        frame_restart_reg <= 1'b1;
      end else if (sbc_mode != SBC_RESTART && sbc_mode != SBC_SLEEP) begin
        frame_restart_reg <= 1'b0;
      end
    end
  end

  // ==========================================
  // Frames skipped after bias switch-on
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      skip_reg <= 3'h0;
    end else if (bias_on) begin
      skip_reg <= 3'h0;
    end else if (frame_done && !skip_done && skip_reg < BIAS_SKIP_MAX) begin
      skip_reg <= skip_reg + 3'h1;
    end
  end

  // ==========================================
  // Start-of-frame resync after a count step
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rec_reg    <= 4'h0;
      sof_enable <= 1'b1;
    end else if (cnt_step) begin
      rec_reg    <= 4'h0;
      sof_enable <= 1'b0;
    end else if (bit_strobe && !sof_enable) begin
      if (!rx_recessive) begin
        rec_reg <= 4'h0;
      end else if (rec_reg + 4'h1 >= REC_WAIT_BITS) begin
        sof_enable <= 1'b1;
      end else begin
        rec_reg <= rec_reg + 4'h1;
      end
    end
  end

  // ==========================================
  // Configuration valid and system error
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      config_valid_bit <= 1'b0;
    end else if (restart_entry || (config_range_write && sbc_mode == SBC_NORMAL)
                 || (state_next == CSW_WOKEN && state_reg != CSW_WOKEN && swk_mode)) begin
      config_valid_bit <= 1'b0;
    end else if (config_valid_set) begin
      config_valid_bit <= 1'b1;
    end
  end

  // A set in the same cycle as a host clear wins, so no error is lost.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      selwake_system_error <= 1'b0;
    end else if (selwake_system_error_set) begin
      selwake_system_error <= 1'b1;
    end else if (check_ok) begin
      selwake_system_error <= 1'b0;
    end else if (selwake_system_error_clear && !(can_mode[2] && !config_valid_bit)) begin
      selwake_system_error <= 1'b0;
    end
  end

  // ==========================================
  // Wake flags
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_pattern <= 1'b0;
      wake_frame   <= 1'b0;
    end else begin
      if (pattern_detected && (state_reg == CSW_WUP_DET1 || pat_wake)) begin
        wake_pattern <= 1'b1;
      end else if (rearm) begin
        wake_pattern <= 1'b0;
      end
      if (frame_wake) begin
        wake_frame <= 1'b1;
      end else if (rearm) begin
        wake_frame <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_wake_flag <= 1'b0;
    end else if (frame_wake || pat_wake) begin
      bus_wake_flag <= 1'b1;
    end else if (bus_wake_clear) begin
      bus_wake_flag <= 1'b0;
    end
  end

  // ==========================================
  // Bus fail and power-on flags
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_fail <= 2'h0;
      por_flag <= 1'b1;
    end else begin
      bus_fail <= (bus_fail_clear ? 2'h0 : bus_fail)
                  | {txd_dom_timeout, bus_dom_timeout};
      if (por_clear) begin
        por_flag <= 1'b0;
      end
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_frame_wake: assert property (frame_wake |=> wake_out && wake_frame && bus_wake_flag)
    else $error("frame wake without flags");
  chk_ovf_wake: assert property ((swk_on && cnt_ovf && swk_mode) |=>
    wake_out && selwake_system_error && frame_error_count == CNT_OVF && state_reg == CSW_WOKEN)
    else $error("overflow did not wake");
  chk_sleep_restart: assert property ((frame_wake && sbc_mode == SBC_SLEEP) |=>
    restart_request && !wake_interrupt)
    else $error("sleep frame wake lacks restart");
  chk_fd_hold: assert property ((fd_tolerance_enable && error_count_disable) |=>
    frame_error_count == '0)
    else $error("counter not held at zero");
  chk_sof_wait: assert property (cnt_step |=> !sof_enable [*1] ##1 !sof_enable)
    else $error("start of frame enabled too early");
  chk_selwake_system_error_stick: assert property ((selwake_system_error && can_mode[2] &&
    !config_valid_bit && !check_ok) |=> selwake_system_error)
    else $error("system error cleared while invalid");
  chk_cfg_check: assert property (check_ok |=> !selwake_system_error &&
    state_reg == CSW_WUF_DET)
    else $error("config check did not enable");
  chk_restart_cfg: assert property (restart_entry |=> !config_valid_bit)
    else $error("restart kept config valid");
  chk_ctrl_write_keep: assert property ((selwake_control_write && config_valid_bit &&
    !config_range_write && !restart_entry && state_next == state_reg) |=> config_valid_bit)
    else $error("control write dropped config valid");
  chk_rearm_flags: assert property ((rearm && !frame_wake && !pattern_detected) |=>
    !wake_frame && !wake_pattern)
    else $error("flags survived rearm");
  chk_no_mode_err: assert property ((!swk_mode && !selwake_system_error &&
    !check_ok) |=> !selwake_system_error)
    else $error("system error set outside selective mode");

  cov_frame_wake: cover property (frame_wake ##1 wake_interrupt);
  cov_overflow: cover property (swk_on && cnt_ovf);
  cov_pattern_wake: cover property (state_reg == CSW_WUP_DET2 && pattern_detected);
  cov_restart_err: cover property (restart_err);

endmodule
`default_nettype wire

// [tb/csw_can_node.sv]
// Far-side CAN node model: received frames, error strobes and bit times.
`timescale 1ns/1ps
`default_nettype none
module csw_can_node
  import csw_pkg::*;
(
  // Clock
  input  wire logic           clk,
  // Received frame
  output logic                frame_done,
  output logic                frame_crc_ok,
  output logic                frame_error,
  output logic [EXT_ID_W-1:0] rx_id,
  output logic                rx_ext,
  output logic [DLC_W-1:0]    rx_dlc,
  output logic [DATA_W-1:0]   rx_data,
  // Error and bit strobes
  output logic                stuff_err,
  output logic                crc_err,
  output logic                form_err,
  output logic                bit_strobe,
  output logic                rx_recessive
);
  // ==========================================
  // Idle levels
  initial begin
    {frame_done, frame_crc_ok, frame_error, stuff_err, crc_err, form_err} = '0;
    {bit_strobe, rx_recessive, rx_ext, rx_dlc, rx_id, rx_data} = '0;
  end

  // ==========================================
  // Frame delivery
  // Fields flip after the strobe, so a late sample of them cannot pass by luck.
  task automatic send(input logic [EXT_ID_W-1:0] id, input logic ext,
                      input logic [DLC_W-1:0] dlc, input logic [DATA_W-1:0] dat,
                      input logic bad);
    {rx_id, rx_ext, rx_dlc, rx_data} = {id, ext, dlc, dat};
    {frame_done, frame_crc_ok, frame_error} = {1'b1, !bad, bad};
    @(posedge clk);
    #10;
    {rx_id, rx_ext, rx_dlc, rx_data} = ~{id, ext, dlc, dat};
    {frame_done, frame_crc_ok, frame_error} = 3'h0;
    @(posedge clk);
    #10;
  endtask

  // ==========================================
  // Protocol errors and recessive bit times
  task automatic err(input int k);
    {form_err, crc_err, stuff_err} = 3'h1 << k;
    @(posedge clk);
    #10;
    {form_err, crc_err, stuff_err} = 3'h0;
    // An idle edge keeps back-to-back calls from lowering and raising a strobe at once.
    @(posedge clk);
    #10;
  endtask

  task automatic rec(input int n);
    repeat (n) begin
      {bit_strobe, rx_recessive} = 2'h3;
      @(posedge clk);
      #10;
      {bit_strobe, rx_recessive} = 2'h0;
      @(posedge clk);
      #10;
    end
  endtask
endmodule
`default_nettype wire

// [tb/csw_selwake_tb_top.sv]
// Self-checking bench for the selective wake frame filter.
`timescale 1ns/1ps
`default_nettype none
module csw_selwake_tb_top;
  import csw_pkg::*;
  // ==========================================
  // Signals
  logic clk = '0, reset_n = '0, fd_tolerance_enable = '0, error_count_disable = '0;
  logic [1:0] sbc_mode = SBC_NORMAL;
  logic [2:0] can_mode = CAN_OFF_LO;
  logic config_valid_set = '0, config_range_write = '0, selwake_control_write = '0;
  logic selwake_system_error_clear = '0, bus_wake_clear = '0, bus_fail_clear = '0, por_clear = '0;
  logic rearm = '0, bias_on = '0, silence_timeout = '0, pattern_detected = '0;
  logic bus_dom_timeout = '0, txd_dom_timeout = '0, cfg_ext = 1'h1;
  logic [EXT_ID_W-1:0] cfg_id = 29'h0123_4567, cfg_id_mask = 29'h1fff_ff00;
  logic [DLC_W-1:0] cfg_dlc = 4'h2;
  logic [DATA_W-1:0] cfg_data_mask = 64'h0000_0000_0000_0080;
  wire logic frame_done, frame_crc_ok, frame_error, rx_ext, stuff_err, crc_err, form_err;
  wire logic bit_strobe, rx_recessive, wake_out, restart_request, wake_interrupt;
  wire logic wake_pattern, wake_frame, bus_wake_flag, selwake_system_error;
  wire logic config_valid_bit, selwake_active, sof_enable, por_flag;
  wire logic [EXT_ID_W-1:0] rx_id;
  wire logic [DLC_W-1:0] rx_dlc;
  wire logic [DATA_W-1:0] rx_data;
  wire logic [CNT_W-1:0] frame_error_count;
  wire logic [1:0] bus_fail;
  int err_total = 0, checks = 0, n_wake = 0, n_int = 0;

  csw_selwake #(.SKIP_FRAMES(3'h1)) DUT (.clk, .reset_n, .sbc_mode, .can_mode,
    .fd_tolerance_enable, .error_count_disable, .config_valid_set, .config_range_write,
    .selwake_control_write, .selwake_system_error_clear, .bus_wake_clear, .bus_fail_clear, .por_clear,
    .rearm, .cfg_id, .cfg_id_mask, .cfg_ext, .cfg_dlc, .cfg_data_mask, .frame_done,
    .frame_crc_ok, .frame_error, .rx_id, .rx_ext, .rx_dlc, .rx_data, .stuff_err, .crc_err,
    .form_err, .bit_strobe, .rx_recessive, .bias_on, .silence_timeout, .pattern_detected,
    .bus_dom_timeout, .txd_dom_timeout, .wake_out, .restart_request, .wake_interrupt,
    .wake_pattern, .wake_frame, .bus_wake_flag, .selwake_system_error, .config_valid_bit,
    .selwake_active, .sof_enable, .frame_error_count, .bus_fail, .por_flag);
  csw_can_node node (.clk, .frame_done, .frame_crc_ok, .frame_error, .rx_id, .rx_ext,
    .rx_dlc, .rx_data, .stuff_err, .crc_err, .form_err, .bit_strobe, .rx_recessive);

  // ==========================================
  // Clock, wake pulse tally and helpers
  always #50 clk = ~clk;
  always @(posedge clk) begin
    n_wake += int'(wake_out);
    n_int += int'(wake_interrupt);
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask

  task automatic pulse(ref logic s);
    s = 1'h1;
    cyc(1);
    s = 1'h0;
  endtask

  task automatic print_verdict;
    if (err_total == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ==========================================
  // Watchdog: the sequence needs well under a thousand cycles.
  initial begin
    #400_000;
    err_total++;
    print_verdict;
  end

  // ==========================================
  // Sequence
  initial begin
    cyc(12);
    reset_n = 1'h1;
    chk({por_flag, selwake_system_error, frame_error_count, sof_enable}, 9'h101, "reset");
    can_mode = 3'h3;
    cyc(1);
    for (int k = 0; k < 3; k++) node.err(k);
    chk(frame_error_count, 3, "count up");
    chk(sof_enable, 0, "sof wait");
    node.rec(5);
    chk(sof_enable, 0, "sof early");
    node.rec(5);
    chk(sof_enable, 1, "sof back");
    node.send(29'h0, 1'h0, 4'h0, 64'h0, 1'h0);
    chk(frame_error_count, 2, "count down");
    {fd_tolerance_enable, error_count_disable} = 2'h3;
    node.err(0);
    chk(frame_error_count, 0, "held zero");
    {fd_tolerance_enable, error_count_disable} = 2'h0;
    can_mode = CAN_WAKE;
    node.err(0);
    chk(frame_error_count, 0, "wake mode count");
    pulse(config_valid_set);
    can_mode = 3'h5;
    cyc(2);
    pulse(selwake_control_write);
    chk({selwake_system_error, config_valid_bit, selwake_active}, 3'h3, "enable");
    chk(frame_error_count, 0, "entry clear");
    for (int k = 0; k < 4; k++) node.send(k == 0 ? 29'h0133_4567 : 29'h0123_4500, 1'h1,
      k == 1 ? 4'h3 : 4'h2, k == 2 ? 64'h0000_0000_0000_0040 : 64'h0000_0000_0000_0080, k == 3);
    cyc(2);
    chk(n_wake, 0, "bad frame woke");
    pulse(bias_on);
    node.send(29'h0123_45aa, 1'h1, 4'h2, 64'h0000_0000_0000_00c0, 1'h0);
    chk(wake_frame, 0, "frame after bias");
    node.send(29'h0123_45aa, 1'h1, 4'h2, 64'h0000_0000_0000_00c0, 1'h0);
    cyc(2);
    chk({wake_frame, bus_wake_flag, config_valid_bit}, 3'h6, "frame wake");
    chk(n_int, 1, "wake interrupt");
    node.err(0);
    chk(frame_error_count, 0, "frozen");
    pulse(rearm);
    cyc(2);
    chk({wake_frame, selwake_system_error}, 2'h1, "rearm");
    pulse(selwake_system_error_clear);
    pulse(bus_wake_clear);
    chk({selwake_system_error, bus_wake_flag}, 2'h2, "sticky error");
    pulse(pattern_detected);
    cyc(1);
    chk({wake_pattern, bus_wake_flag}, 2'h3, "pattern wake");
    pulse(rearm);
    can_mode = CAN_OFF_LO;
    cyc(2);
    chk(wake_pattern, 0, "pattern clear");
    pulse(config_valid_set);
    pulse(selwake_system_error_clear);
    can_mode = 3'h7;
    cyc(2);
    chk({selwake_system_error, selwake_active}, 2'h1, "re-enable");
    node.err(0);
    pulse(silence_timeout);
    chk({frame_error_count, selwake_active}, 7'h01, "silence clear");
    repeat (31) node.err(0);
    chk(frame_error_count, CNT_LIMIT, "at limit");
    node.err(1);
    cyc(2);
    chk({frame_error_count, selwake_system_error}, {CNT_OVF, 1'h1}, "overflow");
    chk(n_wake, 3, "overflow wake");
    pulse(bus_dom_timeout);
    pulse(txd_dom_timeout);
    chk(bus_fail, 2'h3, "timeouts");
    pulse(por_clear);
    chk(por_flag, 0, "power flag clear");
    pulse(bus_fail_clear);
    chk(bus_fail, 2'h0, "fail clear");
    pulse(config_valid_set);
    pulse(rearm);
    cyc(1);
    pulse(config_range_write);
    chk({selwake_system_error, config_valid_bit, selwake_active}, 3'h4, "range write");
    sbc_mode = SBC_RESTART;
    pulse(config_valid_set);
    chk(config_valid_bit, 0, "restart clears valid");
    print_verdict;
  end
endmodule
`default_nettype wire
